// *** src/qsa_pkg.sv ***
package qsa_pkg;
  // channel count and result width
  localparam int NUM_CH      = 4;
  localparam int RES_W       = 12;
  localparam int CH_W        = 2;
  // conversion sequence length in converter clock edges
  localparam int SEQ_EDGES_SYNC  = 78;
  localparam int SEQ_EDGES_ASYNC = 79;
  localparam int EDGE_PER_CH     = 19;
  // internal oscillator: converter tick every OSC_DIV system clocks
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_PERIOD_NS = 400;
  localparam int OSC_DIV       = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [RES_W-1:0] RESULT_RESET = 12'h000;

  typedef enum logic [1:0]
  {
    QSA_IDLE  = 2'b00,
    QSA_CONV  = 2'b01,
    QSA_READY = 2'b10
  } qsa_state_t;
endpackage

// *** src/qsa_sync.sv ***
module qsa_sync
#(
  parameter logic RST_VAL = 1'b0
)
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);
  // -------------------------------------------------------------
  // two-stage synchroniser
  // -------------------------------------------------------------
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  // first stage feeds only the second
  always_comb
  begin
    meta_d = din;
    sync_d = meta_q;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      // reset to the pin's idle level so no false edge follows reset
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q;
endmodule

// *** src/qsa_buf2.sv ***
module qsa_buf2
#(
  parameter int WIDTH = 12
)
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  // -------------------------------------------------------------
  // two-entry buffer, head in slot 0
  // -------------------------------------------------------------
  logic [WIDTH-1:0] mem_q [2];
  logic [WIDTH-1:0] mem_d [2];
  logic [1:0]       cnt_q;
  logic [1:0]       cnt_d;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[0];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // shift on pop so the head is always slot 0
  always_comb
  begin
    mem_d[0] = mem_q[0];
    mem_d[1] = mem_q[1];
    cnt_d    = cnt_q;
    if (pop)
    begin
      mem_d[0] = mem_q[1];
    end
    if (push)
    begin
      if (cnt_q == 2'h0 || (cnt_q == 2'h1 && pop))
      begin
        mem_d[0] = in_data;
      end
      else
      begin
        mem_d[1] = in_data;
      end
    end
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      cnt_q    <= 2'h0;
    end
    else
    begin
      mem_q <= mem_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

// *** src/qsa_host_port.sv ***
// How it works
// - a rising trigger edge puts all four track/holds into hold and starts a sequence.
// - channels are digitised one after another, channel 1 first and channel 4 last.
// - the trigger is synchronised and taken at any time regardless of select and read.
// - conversion status appears on the active-low ready output.
// - ready goes low only after all four results are stored.
// - the result bus is enabled only while read and select are both low.
// - four successive reads return channels 1, 2, 3, 4 with no address.
// - bus accesses are seen only while select is low.
// - converter ticks come from the clock pin or the internal oscillator when strapped low.
// - each result sits on a 12-bit two's-complement bus, msb on the top line.
// - the track/holds return to tracking at the falling edge of ready.
// - a full sequence takes 78 or 79 converter clock edges.
module qsa_host_port
#(
  parameter int RES_W  = qsa_pkg::RES_W,
  parameter int NUM_CH = qsa_pkg::NUM_CH
)
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             conversion_trigger,
  input  wire logic             chip_select_n,
  input  wire logic             read_n,
  input  wire logic             conv_clk_pin,
  input  wire logic             osc_strap_n,
  input  wire logic [RES_W-1:0] sample_data,
  input  wire logic             sample_valid,
  output logic                  sample_req,
  output logic      [1:0]       sample_ch,
  output logic      [NUM_CH-1:0] hold,
  output logic                  ready_n,
  output logic      [RES_W-1:0] result_bus_o,
  output logic                  result_bus_oe
);
  // -------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------
  logic trig_s;
  logic cs_n_s;
  logic rd_n_s;
  logic cclk_s;
  logic strap_n_s;

  qsa_sync u_sync_trig  (.clk(clk), .rst(rst), .din(conversion_trigger), .dout(trig_s));
  qsa_sync #(.RST_VAL(1'b1)) u_sync_cs
    (.clk(clk), .rst(rst), .din(chip_select_n), .dout(cs_n_s));
  qsa_sync #(.RST_VAL(1'b1)) u_sync_rd
    (.clk(clk), .rst(rst), .din(read_n), .dout(rd_n_s));
  qsa_sync u_sync_cclk  (.clk(clk), .rst(rst), .din(conv_clk_pin),       .dout(cclk_s));
  qsa_sync u_sync_strap (.clk(clk), .rst(rst), .din(osc_strap_n),        .dout(strap_n_s));

  // -------------------------------------------------------------
  // converter tick source
  // -------------------------------------------------------------
  logic       trig_prev_q;
  logic       cclk_prev_q;
  logic [5:0] osc_cnt_q;
  logic [5:0] osc_cnt_d;
  logic       trig_rise;
  logic       tick;

  assign trig_rise = trig_s && !trig_prev_q;

  // strap low selects the oscillator; free-running divider
  always_comb
  begin
    osc_cnt_d = osc_cnt_q + 6'h01;
    if (osc_cnt_q == 6'(qsa_pkg::OSC_DIV - 1))
    begin
      osc_cnt_d = 6'h00;
    end
  end

  assign tick = strap_n_s ? (cclk_s && !cclk_prev_q)
                          : (osc_cnt_q == 6'(qsa_pkg::OSC_DIV - 1));

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      trig_prev_q <= 1'b0;
      cclk_prev_q <= 1'b0;
      osc_cnt_q   <= 6'h00;
    end
    else
    begin
      trig_prev_q <= trig_s;
      cclk_prev_q <= cclk_s;
      osc_cnt_q   <= osc_cnt_d;
    end
  end

  // -------------------------------------------------------------
  // conversion sequencer
  // -------------------------------------------------------------
  qsa_pkg::qsa_state_t state_q;
  qsa_pkg::qsa_state_t state_d;
  logic [6:0]       edge_q;
  logic [6:0]       edge_d;
  logic [6:0]       edge_end_q;
  logic [6:0]       edge_end_d;
  logic [1:0]       conv_ch_q;
  logic [1:0]       conv_ch_d;
  logic             conv_done_q;
  logic             conv_done_d;
  logic             hold_q;
  logic             hold_d;
  logic             ready_n_q;
  logic             ready_n_d;
  logic [RES_W-1:0] res_q [NUM_CH];
  logic [RES_W-1:0] res_d [NUM_CH];
  logic             read_start;
  logic             read_ack;

  // a trigger landing on a tick costs one extra edge of alignment
  always_comb
  begin
    state_d    = state_q;
    edge_d     = edge_q;
    edge_end_d = edge_end_q;
    conv_ch_d  = conv_ch_q;
    conv_done_d = conv_done_q;
    hold_d     = hold_q;
    ready_n_d  = ready_n_q;
    res_d      = res_q;
    if (trig_rise)
    begin
      state_d    = qsa_pkg::QSA_CONV;
      hold_d     = 1'b1;
      ready_n_d  = 1'b1;
      edge_d     = tick ? 7'h01 : 7'h00;
      conv_ch_d  = 2'h0;
      conv_done_d = 1'b0;
      edge_end_d = tick ? 7'(qsa_pkg::SEQ_EDGES_ASYNC)
                        : 7'(qsa_pkg::SEQ_EDGES_SYNC);
    end
    else
    begin
      case (state_q)
        qsa_pkg::QSA_CONV:
        begin
          if (tick)
          begin
            edge_d = edge_q + 7'h01;
          end
          // channel result arrives in strict order
          if (sample_valid && !conv_done_q)
          begin
            res_d[conv_ch_q] = sample_data;
            if (conv_ch_q != 2'(NUM_CH - 1))
            begin
              conv_ch_d = conv_ch_q + 2'h1;
            end
            else
            begin
              conv_done_d = 1'b1;
            end
          end
          if (tick && edge_q + 7'h01 >= edge_end_q && conv_done_q)
          begin
            state_d   = qsa_pkg::QSA_READY;
            ready_n_d = 1'b0;
            hold_d    = 1'b0;
          end
        end
        qsa_pkg::QSA_READY:
        begin
          if (read_start)
          begin
            ready_n_d = 1'b1;
          end
        end
        default:
        begin
          state_d = qsa_pkg::QSA_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q    <= qsa_pkg::QSA_IDLE;
      edge_q     <= 7'h00;
      edge_end_q <= 7'h00;
      conv_ch_q  <= 2'h0;
      conv_done_q <= 1'b0;
      hold_q     <= 1'b0;
      ready_n_q  <= 1'b1;
      for (int i = 0; i < NUM_CH; i++)
      begin
        res_q[i] <= qsa_pkg::RESULT_RESET;
      end
    end
    else
    begin
      state_q    <= state_d;
      edge_q     <= edge_d;
      edge_end_q <= edge_end_d;
      conv_ch_q  <= conv_ch_d;
      conv_done_q <= conv_done_d;
      hold_q     <= hold_d;
      ready_n_q  <= ready_n_d;
      res_q      <= res_d;
    end
  end

  // request the current channel until all four results are in or edge 76 (EDGE_PER_CH * NUM_CH) is reached
  assign sample_req = (state_q == qsa_pkg::QSA_CONV) && !conv_done_q
                      && (edge_q < 7'(qsa_pkg::EDGE_PER_CH * NUM_CH));
  assign sample_ch  = conv_ch_q;
  assign hold       = {NUM_CH{hold_q}};
  assign ready_n    = ready_n_q;

  // -------------------------------------------------------------
  // host read port
  // -------------------------------------------------------------
  logic       sel_rd;
  logic       sel_rd_prev_q;
  logic [2:0] rd_ptr_q;
  logic [2:0] rd_ptr_d;
  logic       buf_in_ready;
  logic       buf_out_valid;
  logic [RES_W-1:0] buf_out_data;
  logic [RES_W-1:0] bus_q;
  logic [RES_W-1:0] bus_d;
  logic       oe_q;
  logic       oe_d;
  logic       push;

  assign sel_rd     = !cs_n_s && !rd_n_s;
  assign read_start = sel_rd && !sel_rd_prev_q;
  // words enter the buffer in channel order while results are valid
  assign push = (state_q != qsa_pkg::QSA_CONV) && (rd_ptr_q < 3'(NUM_CH));
  assign read_ack = read_start && buf_out_valid;

  // pointer back to channel 1 on trigger
  always_comb
  begin
    rd_ptr_d = rd_ptr_q;
    if (trig_rise)
    begin
      rd_ptr_d = 3'h0;
    end
    else if (push && buf_in_ready)
    begin
      rd_ptr_d = rd_ptr_q + 3'h1;
    end
  end

  qsa_buf2 #(.WIDTH(RES_W)) u_buf
  (
    .clk       (clk),
    .rst       (rst | trig_rise),
    .in_valid  (push),
    .in_ready  (buf_in_ready),
    .in_data   (res_q[rd_ptr_q[1:0]]),
    .out_valid (buf_out_valid),
    .out_ready (read_ack),
    .out_data  (buf_out_data)
  );

  // bus word latched at read start, held until the next read start
  always_comb
  begin
    bus_d = bus_q;
    oe_d  = sel_rd;
    if (read_ack)
    begin
      bus_d = buf_out_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sel_rd_prev_q <= 1'b0;
      rd_ptr_q      <= 3'h0;
      bus_q         <= qsa_pkg::RESULT_RESET;
      oe_q          <= 1'b0;
    end
    else
    begin
      sel_rd_prev_q <= sel_rd;
      rd_ptr_q      <= rd_ptr_d;
      bus_q         <= bus_d;
      oe_q          <= oe_d;
    end
  end

  assign result_bus_o  = bus_q;
  assign result_bus_oe = oe_q;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  // pins as seen at the block's edge, ahead of the synchronisers
  sequence s_read_strobe;
    !chip_select_n && !read_n;
  endsequence

  a_oe_needs_strobe: assert property (@(posedge clk) disable iff (rst)
    result_bus_oe |-> ($past(chip_select_n, 3) == 1'b0 && $past(read_n, 3) == 1'b0))
    else $error("bus enabled without select and read");
  a_oe_follows: assert property (@(posedge clk) disable iff (rst)
    s_read_strobe [*3] |=> result_bus_oe)
    else $error("bus not enabled on selected read");
  a_ready_after_conv: assert property (@(posedge clk) disable iff (rst)
    $fell(ready_n) |-> $past(state_q) == qsa_pkg::QSA_CONV)
    else $error("ready fell outside conversion");
  a_trig_holds: assert property (@(posedge clk) disable iff (rst)
    trig_rise |=> hold == {NUM_CH{1'b1}} && ready_n)
    else $error("trigger did not hold all channels");
  a_track_at_ready: assert property (@(posedge clk) disable iff (rst)
    $fell(ready_n) |-> hold == '0)
    else $error("still holding at ready");
  a_ptr_reset: assert property (@(posedge clk) disable iff (rst)
    trig_rise |=> rd_ptr_q == 3'h0)
    else $error("read pointer not reset");
  a_ready_clear: assert property (@(posedge clk) disable iff (rst)
    (read_start && state_q == qsa_pkg::QSA_READY && !trig_rise) |=> ready_n)
    else $error("ready not cleared by read");
  a_edge_count: assert property (@(posedge clk) disable iff (rst)
    $fell(ready_n) |-> (edge_end_q == 7'(qsa_pkg::SEQ_EDGES_SYNC)
                        || edge_end_q == 7'(qsa_pkg::SEQ_EDGES_ASYNC)))
    else $error("sequence length wrong");
  a_ch_order: assert property (@(posedge clk) disable iff (rst)
    (sample_valid && state_q == qsa_pkg::QSA_CONV && !trig_rise
     && conv_ch_q != 2'h3) |=> conv_ch_q == $past(conv_ch_q) + 2'h1)
    else $error("channel order broken");
endmodule

// *** verification/qsa_core_model.sv ***
module qsa_core_model
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        sample_req,
  input  wire logic [1:0]  sample_ch,
  input  wire logic [47:0] samples,
  input  wire logic [3:0]  lat,
  output logic      [11:0] sample_data,
  output logic             sample_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] cnt_q;

  // --------------------------------
  // analog core: one result per request
  // --------------------------------
  // lat sets a prompt or slow answer; valid is a one-cycle pulse
  always_ff @(posedge clk)
  begin
    if (rst || !sample_req || sample_valid)
    begin
      cnt_q        <= 4'h0;
      sample_valid <= 1'b0;
    end
    else if (cnt_q == lat)
      sample_valid <= 1'b1;
    else
      cnt_q <= cnt_q + 4'h1;
  end

  // data lines churn outside the pulse so a stale sample never looks right
  assign sample_data = sample_valid ? samples[sample_ch*12 +: 12]
                                    : ~samples[11:0] ^ {8'h00, cnt_q};
endmodule

// *** verification/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        rst;
  logic        trig;
  logic        cs_n;
  logic        rd_n;
  logic        cclk;
  logic        cclk_en;
  logic        strap_n;
  logic        svalid;
  logic        sreq;
  logic        ready_n;
  logic        oe;
  logic [11:0] sdata;
  logic [11:0] bus;
  logic [1:0]  sch;
  logic [3:0]  hold;
  logic [3:0]  lat;
  logic [47:0] samples;
  int          err_count;
  int          checks_done;
  int          seed;
  int          nval;
  int          nedge;

  // oscillator span in system clocks: 78 or 79 ticks, first tick after up to one period
  localparam int OSC_LO = (qsa_pkg::SEQ_EDGES_SYNC - 1) * qsa_pkg::OSC_DIV;
  localparam int OSC_HI = qsa_pkg::SEQ_EDGES_ASYNC * qsa_pkg::OSC_DIV;

  qsa_host_port u_dut
  (
    .clk                (clk),
    .rst                (rst),
    .conversion_trigger (trig),
    .chip_select_n      (cs_n),
    .read_n             (rd_n),
    .conv_clk_pin       (cclk),
    .osc_strap_n        (strap_n),
    .sample_data        (sdata),
    .sample_valid       (svalid),
    .sample_req         (sreq),
    .sample_ch          (sch),
    .hold               (hold),
    .ready_n            (ready_n),
    .result_bus_o       (bus),
    .result_bus_oe      (oe)
  );

  qsa_core_model u_core
  (
    .clk          (clk),
    .rst          (rst),
    .sample_req   (sreq),
    .sample_ch    (sch),
    .samples      (samples),
    .lat          (lat),
    .sample_data  (sdata),
    .sample_valid (svalid)
  );

  // --------------------------------
  // clocks
  // --------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // converter clock pin, six system clocks a period; frozen at its current level when strapped
  initial
  begin
    cclk = 1'b0;
    forever
    begin
      repeat (3) @(negedge clk);
      // offset from the trigger's edge so edge counting never races it
      #2;
      if (cclk_en)
        cclk = ~cclk;
    end
  end

  always @(posedge cclk)
    nedge++;

  // --------------------------------
  // checking helpers
  // --------------------------------
  task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // the fifth read repeats the last channel
  function automatic logic [11:0] exp_data(input int k);
    return samples[((k > 3) ? 3 : k)*12 +: 12];
  endfunction

  // every finished sample must belong to the next channel in turn; looked at mid-cycle
  always @(negedge clk)
  begin
    if (!rst && svalid === 1'b1)
    begin
      chk("sample_ch", 12'(nval), {10'h000, sch});
      nval++;
    end
  end

  // --------------------------------
  // stimulus tasks
  // --------------------------------
  task automatic convert(input logic osc);
    int t;
    @(negedge clk);
    strap_n = ~osc;
    cclk_en = ~osc;
    samples = {16'($random(seed)), $random(seed)};
    lat     = 4'($random(seed));
    cs_n    = 1'($random(seed));
    nval    = 0;
    repeat (6) @(negedge clk);
    trig  = 1'b1;
    nedge = 0;
    t = 0;
    while (hold !== 4'hF && t < 8)
    begin
      @(negedge clk);
      t++;
    end
    chk("hold", 12'h00F, {8'h00, hold});
    chk("ready_conv", 12'h001, {11'h000, ready_n});
    trig  = 1'b0;
    t     = 0;
    while (ready_n !== 1'b0 && t < 4000)
    begin
      @(negedge clk);
      t++;
    end
    if (osc)
      chk("osc_span", 12'h001, {11'h000, t >= OSC_LO && t <= OSC_HI});
    else
      chk("edges", 12'h001, {11'h000, nedge == 78 || nedge == 79});
    chk("ready_low", 12'h000, {11'h000, ready_n});
    chk("samples_done", 12'h004, 12'(nval));
    chk("hold_track", 12'h000, {8'h00, hold});
    cs_n = 1'b1;
  endtask

  task automatic rd(input logic sel, input logic [11:0] exp);
    @(negedge clk);
    cs_n = ~sel;
    rd_n = 1'b0;
    repeat (5) @(negedge clk);
    chk("oe_on", {11'h000, sel}, {11'h000, oe});
    if (sel)
    begin
      chk("result_bus", exp, bus);
      chk("ready_clear", 12'h001, {11'h000, ready_n});
    end
    else
      chk("ready_kept", 12'h000, {11'h000, ready_n});
    rd_n = 1'b1;
    repeat (5) @(negedge clk);
    chk("oe_off", 12'h000, {11'h000, oe});
    cs_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // --------------------------------
  // main sequence
  // --------------------------------
  initial
  begin
    seed        = 32'h968bc544;
    err_count   = 0;
    checks_done = 0;
    nval        = 0;
    nedge       = 0;
    rst         = 1'b1;
    trig        = 1'b0;
    cs_n        = 1'b1;
    rd_n        = 1'b1;
    cclk_en     = 1'b1;
    strap_n     = 1'b1;
    lat         = 4'h0;
    samples     = 48'h0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk("ready_rst", 12'h001, {11'h000, ready_n});
    chk("oe_rst", 12'h000, {11'h000, oe});
    // last pass runs from the internal oscillator; each pass starts at channel 1
    for (int i = 0; i < 5; i++)
    begin
      convert(i == 4);
      rd(1'b0, 12'h000);
      for (int k = 0; k < 5; k++)
        rd(1'b1, exp_data(k));
    end
    print_verdict();
  end

  // hang guard, about five times the expected run
  initial
  begin
    #300000;
    err_count++;
    print_verdict();
  end
endmodule
